// File: rtl/sbcp_port.sv
`timescale 1ns/1ps
// Behaviour
// - one shared command bus, both directions
// - idle, lock, prefetch, barrier codes 0000-0100
// - set dirty 0101, block write 0110/0111
// - read misses 1000-1011 per slot, modify
// - victim 1100; reserved 1101 never driven
// - store-conditional misses 1110 and 1111
// - flush probe evicts, returns dirty data
// - invalidate probe and set-shared probe
// - read probes supply block, share or invalidate
// - 128-bit data bus shared by all
// - request seen high: no drive next
// - request seen low: drive next edge
// - cache idle finishes current, starts none
module sbcp_port import sbcp_pkg::*; (
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              ce_i,
    // core side: command requests
    input  wire logic              req_valid_i,
    input  wire logic [CMD_W-1:0]  req_cmd_i,
    output logic                   req_ready_o,
    // core side: outgoing block data
    input  wire logic              wdata_valid_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic                   wdata_ready_o,
    // core side: incoming data
    output logic                   rdata_valid_o,
    output logic [DATA_W-1:0]      rdata_o,
    // core side: probes
    output logic                   probe_valid_o,
    output logic [CMD_W-1:0]       probe_cmd_o,
    output logic                   probe_inval_o,
    output logic                   probe_shared_o,
    output logic                   probe_supply_o,
    // cache access control
    input  wire logic              cache_start_i,
    input  wire logic              cache_idle_request_i,
    output logic                   cache_active_o,
    // system pins
    input  wire logic [CMD_W-1:0]  cmd_in_i,
    output logic [CMD_W-1:0]       cmd_out_o,
    output logic                   cmd_oe_o,
    input  wire logic              cmd_ack_i,
    input  wire logic              data_ack_i,
    input  wire logic              data_bus_req_i,
    input  wire logic [DATA_W-1:0] data_in_i,
    output logic [DATA_W-1:0]      data_out_o,
    output logic                   data_oe_o
);

    // reset release through two flops
    logic [1:0] rst_q;
    wire        rst_n = rst_q[1];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    // pin synchronisers; stage one is read only by stage two
    localparam int PW = CMD_W + 4;
    logic [PW-1:0]     pin_s1;
    logic [PW-1:0]     pin_s2;
    logic [DATA_W-1:0] dat_s1;
    logic [DATA_W-1:0] dat_s2;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            dat_s1 <= '0;
            dat_s2 <= '0;
        end else if (ce_i) begin
            pin_s1 <= {cmd_in_i, cmd_ack_i, data_ack_i,
                       data_bus_req_i, cache_idle_request_i};
            pin_s2 <= pin_s1;
            dat_s1 <= data_in_i;
            dat_s2 <= dat_s1;
        end
    end

    wire [CMD_W-1:0] cmd_s  = pin_s2[PW-1:4];
    wire             cack_s = pin_s2[3];
    wire             dack_s = pin_s2[2];
    wire             dbr_s  = pin_s2[1];
    wire             idle_s = pin_s2[0];

    // outgoing data buffer
    sbcp_fifo_if #(.W(DATA_W)) wq ();

    sbcp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .ce_i    (ce_i),
        .f       (wq.fifo)
    );

    // a full buffer stalls the core through wdata_ready_o
    assign wq.wr_valid = wdata_valid_i;
    assign wq.wr_data  = wdata_i;

    // state and echo tracking
    sbcp_state_t      st;
    sbcp_state_t      next_st;
    logic [0:0]       wcnt;
    logic [1:0]       cmd_echo;
    logic [1:0]       oe_echo;
    logic [CMD_W-1:0] cmd_prev;
    logic             supply_pend;
    logic [2:0]       ccnt;

    // request decode; reserved code is never taken
    wire req_legal = req_cmd_i != CPU_RESERVED;
    wire take_req  = req_valid_i & req_ready_o & req_legal;
    wire is_write  = cmd_out_o inside {CPU_WRITE_BLK,
                                       CPU_WRITE_BLK_LOCK};
    wire cmd_done  = (st == S_CMD) & cack_s;
    // each acked word was on the bus two edges earlier
    wire pop       = (st == S_DATA) & dack_s & oe_echo[1];
    wire blk_end   = pop & (wcnt == BLOCK_LAST);
    assign wq.rd_ready = pop;

    // drive only when the request was seen low; one gap per word
    wire next_oe = (next_st == S_DATA) & wq.rd_valid & ~pop
                   & ~dbr_s;

    // probes: new code on a quiet bus, not our own echo
    wire probe_new = ~cmd_oe_o & (cmd_echo == 2'h0)
                     & (cmd_prev == SYS_NOP)
                     & sbcp_probe_ok(cmd_s);
    wire p_inval  = cmd_s inside {SYS_FLUSH, SYS_INVALIDATE,
                                  SYS_PROBE_READ_INVALIDATE};
    wire p_shared = cmd_s inside {SYS_SET_SHARED, SYS_READ_SHARED};
    wire p_supply = cmd_s inside {SYS_FLUSH, SYS_READ, SYS_READ_SHARED,
                                  SYS_PROBE_READ_INVALIDATE};

    // next state
    always_comb begin
        next_st = st;
        unique case (st)
            S_IDLE: begin
                if (supply_pend) begin
                    next_st = S_DATA;
                end else if (take_req) begin
                    next_st = S_CMD;
                end
            end
            S_CMD: begin
                if (cmd_done) begin
                    next_st = is_write ? S_DATA : S_IDLE;
                end
            end
            S_DATA: begin
                if (blk_end) begin
                    next_st = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            st   <= S_IDLE;
            wcnt <= 1'h0;
        end else if (ce_i) begin
            st   <= next_st;
            wcnt <= (st != S_DATA) ? 1'h0 : wcnt + 1'(pop);
        end
    end

    // command bus drive, held until acknowledged
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cmd_out_o <= CMD_RST;
            cmd_oe_o  <= 1'b0;
            cmd_echo  <= 2'h0;
        end else if (ce_i) begin
            if (st == S_IDLE && !supply_pend && take_req) begin
                cmd_out_o <= req_cmd_i;
                cmd_oe_o  <= 1'b1;
            end else if (cmd_done) begin
                cmd_oe_o  <= 1'b0;
            end
            cmd_echo <= {cmd_echo[0], cmd_oe_o};
        end
    end

    // ready is registered; it reflects the coming idle state
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            req_ready_o <= 1'b0;
        end else if (ce_i) begin
            req_ready_o <= (next_st == S_IDLE) & ~supply_pend
                           & ~(probe_new & p_supply);
        end
    end

    // data bus drive; the head word is copied each driven cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            data_oe_o  <= 1'b0;
            data_out_o <= '0;
            oe_echo    <= 2'h0;
        end else if (ce_i) begin
            data_oe_o  <= next_oe;
            data_out_o <= next_oe ? wq.rd_data : data_out_o;
            oe_echo    <= {oe_echo[0], data_oe_o};
        end
    end

    // the fifo ready flag leaves through its own flop
    assign wdata_ready_o = wq.wr_ready;

    // incoming words: acked while we were not driving
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_valid_o <= 1'b0;
            rdata_o       <= '0;
        end else if (ce_i) begin
            rdata_valid_o <= dack_s & ~oe_echo[1];
            rdata_o       <= (dack_s & ~oe_echo[1]) ? dat_s2 : rdata_o;
        end
    end

    // probe reporting; a set in the clearing cycle wins
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            probe_valid_o  <= 1'b0;
            probe_cmd_o    <= SYS_NOP;
            probe_inval_o  <= 1'b0;
            probe_shared_o <= 1'b0;
            probe_supply_o <= 1'b0;
            cmd_prev       <= SYS_NOP;
            supply_pend    <= 1'b0;
        end else if (ce_i) begin
            probe_valid_o  <= probe_new;
            probe_cmd_o    <= probe_new ? cmd_s : probe_cmd_o;
            probe_inval_o  <= probe_new & p_inval;
            probe_shared_o <= probe_new & p_shared;
            probe_supply_o <= probe_new & p_supply;
            cmd_prev       <= cmd_oe_o ? SYS_NOP : cmd_s;
            supply_pend    <= (probe_new & p_supply)
                              | (supply_pend & (st != S_IDLE));
        end
    end

    // cache accesses run a fixed length and are never cut short
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cache_active_o <= 1'b0;
            ccnt           <= 3'h0;
        end else if (ce_i) begin
            if (!cache_active_o && cache_start_i && !idle_s) begin
                cache_active_o <= 1'b1;
                ccnt           <= CACHE_OP_CYC - 3'h1;
            end else if (cache_active_o) begin
                cache_active_o <= ccnt != 3'h0;
                ccnt           <= ccnt - 3'h1;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_cmd_issue;
        ce_i && take_req && st == S_IDLE && !supply_pend;
    endsequence

    sequence s_probe(logic [3:0] c);
        ce_i && probe_new && cmd_s == c;
    endsequence

    a_cmd_encode: assert property (
        s_cmd_issue |=> cmd_oe_o && cmd_out_o == $past(req_cmd_i))
        else $error("issued command code differs from request");

    a_no_reserved: assert property (
        cmd_oe_o |-> cmd_out_o != CPU_RESERVED)
        else $error("reserved command driven");

    a_cmd_hold: assert property (
        ce_i && cmd_oe_o && st == S_CMD && !cack_s
        |=> cmd_oe_o && $stable(cmd_out_o))
        else $error("command dropped before acknowledge");

    a_cmd_release: assert property (
        ce_i && cmd_done |=> !cmd_oe_o
        ##1 (!cmd_oe_o || $past(take_req)))
        else $error("command bus held after acknowledge");

    a_req_blocks: assert property (
        ce_i && dbr_s |=> !data_oe_o)
        else $error("data bus driven after request seen");

    a_req_drive: assert property (
        ce_i && !dbr_s && st == S_DATA && next_st == S_DATA
        && wq.rd_valid && !pop |=> data_oe_o)
        else $error("data bus not driven after request released");

    a_flush_probe: assert property (
        s_probe(SYS_FLUSH) |=> probe_valid_o && probe_inval_o
        && probe_supply_o && !probe_shared_o)
        else $error("flush probe misreported");

    a_inval_probe: assert property (
        s_probe(SYS_INVALIDATE) |=> probe_inval_o && !probe_supply_o)
        else $error("invalidate probe misreported");

    a_read_probe: assert property (
        s_probe(SYS_READ_SHARED) |=> probe_supply_o && probe_shared_o
        ##1 supply_pend || st == S_DATA)
        else $error("read probe did not schedule supply");

    a_cache_idle: assert property (
        ce_i && idle_s && !cache_active_o |=> !cache_active_o)
        else $error("cache access started while idled");

    a_cache_len: assert property (
        ce_i && $rose(cache_active_o) ##0 ce_i[*4] |=> !cache_active_o)
        else $error("cache access length wrong");

endmodule // sbcp_port

// File: rtl/sbcp_pkg.sv
package sbcp_pkg;

    // bus widths and buffer depth
    localparam int CMD_W      = 4;
    localparam int DATA_W     = 128;
    localparam int FIFO_DEPTH = 32;

    // processor-to-system command codes
    localparam logic [3:0] CPU_NOP                = 4'h0;
    localparam logic [3:0] CPU_LOCK               = 4'h1;
    localparam logic [3:0] CPU_PREFETCH           = 4'h2;
    localparam logic [3:0] CPU_PREFETCH_MOD       = 4'h3;
    localparam logic [3:0] CPU_BARRIER            = 4'h4;
    localparam logic [3:0] CPU_SET_DIRTY          = 4'h5;
    localparam logic [3:0] CPU_WRITE_BLK          = 4'h6;
    localparam logic [3:0] CPU_WRITE_BLK_LOCK     = 4'h7;
    localparam logic [3:0] CPU_MISS_SLOT0         = 4'h8;
    localparam logic [3:0] CPU_MISS_SLOT1         = 4'h9;
    localparam logic [3:0] CPU_MISS_MODIFY_SLOT0  = 4'hA;
    localparam logic [3:0] CPU_MISS_MODIFY_SLOT1  = 4'hB;
    localparam logic [3:0] CPU_VICTIM             = 4'hC;
    localparam logic [3:0] CPU_RESERVED           = 4'hD;
    localparam logic [3:0] CPU_MISS_STORE_COND_S0 = 4'hE;
    localparam logic [3:0] CPU_MISS_STORE_COND_S1 = 4'hF;

    // system-to-processor probe codes
    localparam logic [3:0] SYS_NOP                   = 4'h0;
    localparam logic [3:0] SYS_FLUSH                 = 4'h1;
    localparam logic [3:0] SYS_INVALIDATE            = 4'h2;
    localparam logic [3:0] SYS_SET_SHARED            = 4'h3;
    localparam logic [3:0] SYS_READ                  = 4'h4;
    localparam logic [3:0] SYS_READ_SHARED           = 4'h5;
    localparam logic [3:0] SYS_PROBE_READ_INVALIDATE = 4'h7;

    // last word index of a cache block, cycles per cache access, reset values
    localparam logic [0:0] BLOCK_LAST   = 1'h1;
    localparam logic [2:0] CACHE_OP_CYC = 3'h4;
    localparam logic [3:0] CMD_RST      = CPU_NOP;

    typedef enum logic [1:0] {S_IDLE, S_CMD, S_DATA} sbcp_state_t;

    // probe codes the processor understands
    function automatic logic sbcp_probe_ok(input logic [3:0] c);
        return c inside {SYS_FLUSH, SYS_INVALIDATE, SYS_SET_SHARED,
                         SYS_READ, SYS_READ_SHARED,
                         SYS_PROBE_READ_INVALIDATE};
    endfunction

endpackage

// File: rtl/sbcp_fifo_if.sv
`timescale 1ns/1ps
interface sbcp_fifo_if #(parameter int W = 128);
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;
    modport fifo (input wr_valid, wr_data, rd_ready,
                  output wr_ready, rd_valid, rd_data);
    modport user (output wr_valid, wr_data, rd_ready,
                  input wr_ready, rd_valid, rd_data);
endinterface

// File: rtl/sbcp_fifo.sv
`timescale 1ns/1ps
module sbcp_fifo #(
    parameter int WIDTH = 128,
    parameter int DEPTH = 32
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    sbcp_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      cnt;
    logic             space;
    logic             avail;
    logic [AW:0]      next_cnt;
    wire              push = f.wr_valid & space;
    wire              pop  = f.rd_ready & avail;

    // flags are registered so the ready and valid leave from flops
    assign next_cnt   = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign f.wr_ready = space;
    assign f.rd_valid = avail;
    assign f.rd_data  = mem[rd_ptr];

    // storage has no reset, only pointers, count and flags do
    always_ff @(posedge clk_i) begin
        if (ce_i && push) begin
            mem[wr_ptr] <= f.wr_data;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt    <= '0;
            space  <= 1'b1;
            avail  <= 1'b0;
        end else if (ce_i) begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            cnt    <= next_cnt;
            space  <= next_cnt != (AW+1)'(DEPTH);
            avail  <= next_cnt != '0;
        end
    end

endmodule // sbcp_fifo

// File: verif/sbcp_sys_model.sv
`timescale 1ns/1ps
// behavioural system-side controller: acks, probes, fills, bus requests
module sbcp_sys_model import sbcp_pkg::*; (
    input  wire logic              clk_i,
    input  wire logic              cmd_oe_i,
    input  wire logic [DATA_W-1:0] data_out_i,
    input  wire logic              data_oe_i,
    output logic [CMD_W-1:0]       sys_cmd_o,
    output logic                   cmd_ack_o,
    output logic                   data_ack_o,
    output logic [DATA_W-1:0]      sys_data_o,
    output logic                   sys_data_oe_o,
    output logic                   data_bus_req_o,
    output logic                   cache_idle_request_o
);
    int                ack_wait = 1;
    int                c_cnt = 0;
    int                d_cnt = 0;
    logic              ack_own = 1'b0;
    logic              ack_give = 1'b0;
    logic [DATA_W-1:0] seen_q[$];

    // one acknowledge line serves both our own words and fill words
    assign data_ack_o = ack_own | ack_give;

    initial begin
        sys_cmd_o = SYS_NOP; // idle code between probes
        cmd_ack_o = 1'b0;
        sys_data_o = '0;
        sys_data_oe_o = 1'b0;
        data_bus_req_o = 1'b0;
        cache_idle_request_o = 1'b0;
    end

    // ack_wait sets prompt or slow answers; one pulse per command or word
    always @(posedge clk_i) begin
        #1;
        cmd_ack_o = cmd_oe_i && c_cnt == ack_wait;
        c_cnt = cmd_oe_i ? c_cnt + 1 : 0;
        ack_own = data_oe_i && d_cnt == ack_wait;
        if (ack_own) begin
            seen_q.push_back(data_out_i);
        end
        d_cnt = data_oe_i ? d_cnt + 1 : 0;
    end

    // only defined probe codes are ever placed on the bus
    task automatic set_probe(input logic [CMD_W-1:0] c);
        @(posedge clk_i);
        #1;
        sys_cmd_o = c;
    endtask

    // one fill word with its acknowledge, then the lines are released
    task automatic give_word(input logic [DATA_W-1:0] w);
        @(posedge clk_i);
        #1;
        sys_data_o = w;
        sys_data_oe_o = 1'b1;
        ack_give = 1'b1;
        @(posedge clk_i);
        #1;
        sys_data_oe_o = 1'b0;
        ack_give = 1'b0;
    endtask

    // cache is idled for a whole access before the bus is claimed
    task automatic grab_bus(input logic on);
        @(posedge clk_i);
        #1;
        if (on) begin
            cache_idle_request_o = 1'b1;
            repeat (CACHE_OP_CYC + 2) @(posedge clk_i);
            #1;
        end
        data_bus_req_o = on;
    endtask

    task automatic set_idle(input logic on);
        cache_idle_request_o = on;
    endtask
endmodule // sbcp_sys_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top import sbcp_pkg::*; ;
    localparam logic [DATA_W-1:0] W0 = {4{32'hC0DE_0001}};
    localparam logic [DATA_W-1:0] W1 = {4{32'h1357_9BDF}};
    localparam logic [DATA_W-1:0] W2 = {4{32'hFEDC_0246}};
    // probe code list and expected {inval, shared, supply} by code
    localparam logic [3:0] PCODE [6] = '{SYS_FLUSH, SYS_INVALIDATE,
        SYS_SET_SHARED, SYS_READ, SYS_READ_SHARED, SYS_PROBE_READ_INVALIDATE};
    localparam logic [2:0] PEXP [8] = '{3'h0, 3'h5, 3'h4, 3'h2, 3'h1, 3'h3,
        3'h0, 3'h5};

    logic              clk;
    logic              arst_n = 1'b0;
    logic              ce = 1'b1;
    logic              req_valid = 1'b0;
    logic [CMD_W-1:0]  req_cmd = CPU_NOP;
    logic              wdata_valid = 1'b0;
    logic [DATA_W-1:0] wdata = '0;
    logic              cache_start = 1'b0;
    logic              req_ready_o, wdata_ready_o, rdata_valid_o;
    logic [DATA_W-1:0] rdata_o, data_out_o, sys_data, data_in;
    logic              probe_valid_o, probe_inval_o, probe_shared_o;
    logic              probe_supply_o, cache_active_o, cmd_oe_o;
    logic [CMD_W-1:0]  probe_cmd_o, cmd_out_o, sys_cmd, cmd_in;
    logic              cmd_ack, data_ack, data_bus_req, idle_req;
    logic              data_oe_o, sys_data_oe;
    logic [DATA_W-1:0] last_data = '0;
    int                errors = 0;
    int                check_count = 0;

    // released data lines show a value that changes every cycle
    always @(posedge clk) last_data <= data_in;
    assign data_in = data_oe_o ? data_out_o :
                     sys_data_oe ? sys_data : ~last_data;
    assign cmd_in = cmd_oe_o ? cmd_out_o : sys_cmd;

    sbcp_port sbcp_port_inst (.clk_i(clk), .arst_n_i(arst_n), .ce_i(ce),
        .req_valid_i(req_valid), .req_cmd_i(req_cmd),
        .req_ready_o(req_ready_o), .wdata_valid_i(wdata_valid),
        .wdata_i(wdata), .wdata_ready_o(wdata_ready_o),
        .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o),
        .probe_valid_o(probe_valid_o), .probe_cmd_o(probe_cmd_o),
        .probe_inval_o(probe_inval_o), .probe_shared_o(probe_shared_o),
        .probe_supply_o(probe_supply_o), .cache_start_i(cache_start),
        .cache_idle_request_i(idle_req), .cache_active_o(cache_active_o),
        .cmd_in_i(cmd_in), .cmd_out_o(cmd_out_o), .cmd_oe_o(cmd_oe_o),
        .cmd_ack_i(cmd_ack), .data_ack_i(data_ack),
        .data_bus_req_i(data_bus_req), .data_in_i(data_in),
        .data_out_o(data_out_o), .data_oe_o(data_oe_o));

    sbcp_sys_model sbcp_sys_model_inst (.clk_i(clk), .cmd_oe_i(cmd_oe_o),
        .data_out_i(data_out_o), .data_oe_i(data_oe_o), .sys_cmd_o(sys_cmd),
        .cmd_ack_o(cmd_ack), .data_ack_o(data_ack), .sys_data_o(sys_data),
        .sys_data_oe_o(sys_data_oe), .data_bus_req_o(data_bus_req),
        .cache_idle_request_o(idle_req));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string m);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic chk_vec(input logic [DATA_W-1:0] got, exp, input string m);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // valid is held until ready was high at the taking edge
    task automatic push2(input logic [DATA_W-1:0] w0, w1);
        wdata_valid = 1'b1;
        wdata = w0;
        for (int n = 0; n < 40 && wdata_ready_o !== 1'b1; n++) tick();
        tick();
        wdata = w1;
        for (int n = 0; n < 40 && wdata_ready_o !== 1'b1; n++) tick();
        tick();
        wdata_valid = 1'b0;
    endtask

    task automatic issue_cmd(input logic [CMD_W-1:0] c);
        req_valid = 1'b1;
        req_cmd = c;
        for (int n = 0; n < 40 && req_ready_o !== 1'b1; n++) tick();
        tick();
        req_valid = 1'b0;
        for (int n = 0; n < 4 && cmd_oe_o !== 1'b1; n++) tick();
        chk_vec(DATA_W'(cmd_out_o), DATA_W'(c), "command code");
    endtask

    task automatic wait_ready();
        for (int n = 0; n < 80 && req_ready_o !== 1'b1; n++) tick();
        chk_bit(cmd_oe_o, 1'b0, "command bus not released");
    endtask

    // words the model acknowledged, in order
    task automatic chk_sent(input logic [DATA_W-1:0] w0, w1);
        for (int n = 0; n < 60 && sbcp_sys_model_inst.seen_q.size() < 2; n++)
            tick();
        chk_vec(sbcp_sys_model_inst.seen_q[0], w0, "word 0");
        chk_vec(sbcp_sys_model_inst.seen_q[1], w1, "word 1");
        sbcp_sys_model_inst.seen_q.delete();
    endtask

    // every legal outgoing code except idle 0000; block writes carry two words
    task automatic t_cmds();
        logic [CMD_W-1:0] c;
        for (int i = 1; i < 16; i++) begin
            c = CMD_W'(i);
            if (c != CPU_RESERVED) begin
                if (c == CPU_WRITE_BLK || c == CPU_WRITE_BLK_LOCK)
                    push2(W0 ^ DATA_W'(i), W1 ^ DATA_W'(i));
                issue_cmd(c);
                wait_ready();
                if (c == CPU_WRITE_BLK || c == CPU_WRITE_BLK_LOCK)
                    chk_sent(W0 ^ DATA_W'(i), W1 ^ DATA_W'(i));
            end
        end
    endtask

    task automatic t_reserved();
        req_valid = 1'b1;
        req_cmd = CPU_RESERVED;
        repeat (10) begin
            tick();
            chk_bit(cmd_oe_o, 1'b0, "reserved code driven");
        end
        chk_bit(req_ready_o, 1'b1, "ready dropped");
        req_valid = 1'b0;
    endtask

    task automatic t_fill();
        issue_cmd(CPU_MISS_SLOT1);
        wait_ready();
        sbcp_sys_model_inst.give_word(W2);
        for (int n = 0; n < 6 && rdata_valid_o !== 1'b1; n++) tick();
        chk_bit(rdata_valid_o, 1'b1, "fill word missing");
        chk_vec(rdata_o, W2, "fill word");
    endtask

    // slow partner holds the bus; the port must stay off it
    task automatic t_bus_req();
        int n;
        sbcp_sys_model_inst.ack_wait = 4;
        sbcp_sys_model_inst.grab_bus(1'b1);
        push2(W1, W2);
        issue_cmd(CPU_WRITE_BLK);
        repeat (12) begin
            tick();
            chk_bit(data_oe_o, 1'b0, "drove while requested");
        end
        sbcp_sys_model_inst.grab_bus(1'b0);
        for (n = 0; n < 6 && data_oe_o !== 1'b1; n++) tick();
        chk_bit(n <= 3, 1'b1, "late drive");
        wait_ready();
        chk_sent(W1, W2);
        sbcp_sys_model_inst.set_idle(1'b0);
        sbcp_sys_model_inst.ack_wait = 1;
    endtask

    task automatic t_probes();
        logic [CMD_W-1:0] c;
        logic [2:0]       e;
        for (int i = 0; i < 6; i++) begin
            c = PCODE[i];
            e = PEXP[c];
            if (e[0]) push2(W0 + DATA_W'(i), W2 - DATA_W'(i));
            sbcp_sys_model_inst.set_probe(c);
            for (int n = 0; n < 6 && probe_valid_o !== 1'b1; n++) tick();
            chk_vec(DATA_W'(probe_cmd_o), DATA_W'(c), "probe code");
            chk_vec(DATA_W'({probe_inval_o, probe_shared_o, probe_supply_o}),
                    DATA_W'(e), "probe action");
            sbcp_sys_model_inst.set_probe(SYS_NOP);
            if (e[0]) chk_sent(W0 + DATA_W'(i), W2 - DATA_W'(i));
            wait_ready();
            repeat (4) tick();
        end
    endtask

    // fill the buffer to its depth, then drain it as sixteen blocks
    task automatic t_full();
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            wdata_valid = 1'b1;
            wdata = W0 + DATA_W'(i);
            tick();
        end
        wdata_valid = 1'b0;
        chk_bit(wdata_ready_o, 1'b0, "buffer not full");
        for (int i = 0; i < FIFO_DEPTH; i += 2) begin
            issue_cmd(CPU_WRITE_BLK);
            wait_ready();
            chk_sent(W0 + DATA_W'(i), W0 + DATA_W'(i + 1));
        end
    endtask

    // a low enable freezes all state, so no access may start
    task automatic t_ce();
        ce = 1'b0;
        cache_start = 1'b1;
        repeat (6) tick();
        chk_bit(cache_active_o, 1'b0, "moved while frozen");
        chk_bit(req_ready_o, 1'b1, "ready lost while frozen");
        ce = 1'b1;
        cache_start = 1'b0;
    endtask

    // idle arrives mid-access: current access ends, no new one starts
    task automatic t_cache();
        int n;
        cache_start = 1'b1;
        for (n = 0; n < 6 && cache_active_o !== 1'b1; n++) tick();
        sbcp_sys_model_inst.set_idle(1'b1);
        for (n = 0; n < 10 && cache_active_o === 1'b1; n++) tick();
        chk_vec(DATA_W'(n), DATA_W'(CACHE_OP_CYC), "access length");
        repeat (8) begin
            tick();
            chk_bit(cache_active_o, 1'b0, "started while idle");
        end
        sbcp_sys_model_inst.set_idle(1'b0);
        for (n = 0; n < 6 && cache_active_o !== 1'b1; n++) tick();
        chk_bit(cache_active_o, 1'b1, "no start after idle");
        cache_start = 1'b0;
    endtask

    task automatic give_verdict();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // the whole sequence needs a few hundred cycles
    initial begin
        #200000;
        errors++;
        $display("BAD %0t watchdog expired", $time);
        give_verdict();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (4) tick();
        t_cmds();
        t_reserved();
        t_fill();
        t_bus_req();
        t_probes();
        t_full();
        t_ce();
        t_cache();
        give_verdict();
    end
endmodule // tb_top
